/* File: rtl/fcsu_defs.svh */
// Constants for the flash command and status unit
`ifndef FCSU_DEFS_SVH
`define FCSU_DEFS_SVH
// Command codes
`define FCSU_CMD_READ_ARRAY  8'hff
`define FCSU_CMD_READ_ID     8'h90
`define FCSU_CMD_READ_STATUS 8'h70
`define FCSU_CMD_CLEAR_STAT  8'h50
`define FCSU_CMD_ERASE_SETUP 8'h20
`define FCSU_CMD_CONFIRM     8'hd0
`define FCSU_CMD_PROG_SETUP  8'h40
`define FCSU_CMD_PROG_ALT    8'h10
`define FCSU_CMD_SUSPEND     8'hb0
// Status bit positions
`define FCSU_SR_READY        7
`define FCSU_SR_ERS_SUSP     6
`define FCSU_SR_ERS_FAIL     5
`define FCSU_SR_PRG_FAIL     4
`define FCSU_SR_SUPPLY_LOW   3
`define FCSU_SR_PRG_SUSP     2
`define FCSU_SR_PROTECT      1
// Reset value of the status register: ready, no flags
`define FCSU_SR_RESET        8'h80
// Identifier read addresses
`define FCSU_ID_MAKER_ADDR   2'h0
`define FCSU_ID_PART_ADDR    2'h1
// Engine operation times in cycles (shortened stand-ins)
`define FCSU_ERASE_CYCLES    16'h0040
`define FCSU_PROG_CYCLES     16'h0008
// Host command codes for its own user port
`define FCSU_HOP_READ        3'h0
`define FCSU_HOP_WRITE       3'h1
`endif

/* File: rtl/fcsu_pkg.sv */
// Types for the flash command and status unit
package fcsu_pkg;
   typedef enum logic [3:0]
   {
      FCSU_M_ARRAY  = 4'h1,
      FCSU_M_ID     = 4'h2,
      FCSU_M_STATUS = 4'h4,
      FCSU_M_SETUP  = 4'h8
   } fcsu_mode_t;

   typedef enum logic [2:0]
   {
      FCSU_E_IDLE = 3'h1,
      FCSU_E_RUN  = 3'h2,
      FCSU_E_SUSP = 3'h4
   } fcsu_eng_t;
endpackage

/* File: rtl/fcsu_bus_if.sv */
// Byte-wide write/read bus between host and flash command unit
interface fcsu_bus_if #(parameter int AW = 20);
   logic          wr_stb;
   logic          rd_stb;
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic [7:0]    rdata;
   logic          rvalid;

   modport dev  (input wr_stb, rd_stb, addr, wdata, output rdata, rvalid);
   modport host (output wr_stb, rd_stb, addr, wdata, input rdata, rvalid);
endinterface

/* File: rtl/fcsu_device.sv */
// Flash command interface, program/erase engine and status register
// Summary of operation
// - Low supply: reads allowed, program/erase refused
// - FFh and 50h accepted at any address
// - After 70h, next read returns status
// - 90h enters identifier mode, address selects code
// - Erase is 20h then D0h in block
// - Program setup 40h or 10h, then data
// - B0h suspends, D0h resumes, any address
// - Locked block: no array change, operation fails
// - Host writes only defined command codes; fcsu_host forwards any byte, device ignores reserved codes
// - Bit 7 ready; low bits invalid while busy
// - Bit 6 set while erase suspended
// - Bit 5 erase fail, bit 4 program fail
// - Bad erase sequence sets bits 5 and 4
// - Bit 3 supply check at operation start and end
// - Bit 2 set while program suspended
// - Bit 1 set on lock or pin abort
// - Bit 0 reserved, device masks it to 0 on reads
// - Error flags persist until clear-status command
// - Reset enters read array mode
// - After erase/program start, reads return status
`include "fcsu_defs.svh"
module fcsu_device
   import fcsu_pkg::*;
#(
   parameter int AW     = 20,
   parameter int BLK_AW = 16,
   parameter int NBLK   = 16
)
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rst,
   // Bus towards host
   fcsu_bus_if.dev              bus,
   // Supply and lock from logic on this clock; protect comes from a pin
   input  wire logic            supply_low,
   input  wire logic [NBLK-1:0] block_lock,
   input  wire logic            top_block_protect_pin_n,
   // Array side: one-cycle commit strobes
   output logic                 array_erase_stb,
   output logic                 array_prog_stb,
   output logic [AW-1:0]        array_addr,
   output logic [7:0]           array_data,
   input  wire logic [7:0]      array_rdata,
   // Status mirror
   output logic                 ready
);
   localparam logic [7:0] MAKER_CODE = 8'h5a; // Arbitrary identity value
   localparam logic [7:0] PART_CODE  = 8'h3c; // Arbitrary identity value

   typedef struct packed
   {
      fcsu_mode_t    mode;
      logic          setup_erase;
      fcsu_eng_t     eng;
      logic          op_erase;
      logic [15:0]   cnt;
      logic [AW-1:0] op_addr;
      logic [7:0]    op_data;
      logic          susp_req;
      logic [7:0]    sr;
      logic [7:0]    rdata;
      logic          rvalid;
      logic          ers_stb;
      logic          prg_stb;
      logic [2:0]    pin_sync_n;
      logic          pin_lvl_n;
   } fcsu_dev_st_t;

   fcsu_dev_st_t st_r, st_nxt;

   logic [7:0]  cmd;
   logic        locked;
   logic [31:0] blk_idx;

   assign cmd = bus.wdata;

   // Lock check for the target block, top block also guarded by the pin
   always_comb
   begin
      blk_idx = 32'(bus.addr >> BLK_AW);
      locked  = block_lock[blk_idx[$clog2(NBLK)-1:0]] ||
                ((blk_idx == NBLK - 1) && !st_r.pin_lvl_n);
   end

   // Next state
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.rvalid  = 1'b0;
      st_nxt.ers_stb = 1'b0;
      st_nxt.prg_stb = 1'b0;

      // Protect pin is asynchronous: three stages, level taken once the last two agree
      st_nxt.pin_sync_n = {st_r.pin_sync_n[1:0], top_block_protect_pin_n};
      if (st_r.pin_sync_n[2] == st_r.pin_sync_n[1])
         st_nxt.pin_lvl_n = st_r.pin_sync_n[2];

      // Engine progress
      if (st_r.eng == FCSU_E_RUN)
      begin
         if (st_r.susp_req)
         begin
            st_nxt.eng      = FCSU_E_SUSP;
            st_nxt.susp_req = 1'b0;
            st_nxt.sr[`FCSU_SR_READY] = 1'b1;
            if (st_r.op_erase)
               st_nxt.sr[`FCSU_SR_ERS_SUSP] = 1'b1;
            else
               st_nxt.sr[`FCSU_SR_PRG_SUSP] = 1'b1;
         end
         else if (st_r.cnt == 16'h0000)
         begin
            st_nxt.eng = FCSU_E_IDLE;
            st_nxt.sr[`FCSU_SR_READY] = 1'b1;
            // Supply sampled again at the end of the operation, after the check at start
            if (supply_low)
            begin
               st_nxt.sr[`FCSU_SR_SUPPLY_LOW] = 1'b1;
               if (st_r.op_erase)
                  st_nxt.sr[`FCSU_SR_ERS_FAIL] = 1'b1;
               else
                  st_nxt.sr[`FCSU_SR_PRG_FAIL] = 1'b1;
            end
            else if (st_r.op_erase)
               st_nxt.ers_stb = 1'b1;
            else
               st_nxt.prg_stb = 1'b1;
         end
         else
            st_nxt.cnt = st_r.cnt - 16'h0001;
      end

      // Writes from the host
      if (bus.wr_stb)
      begin
         if (st_r.eng == FCSU_E_RUN)
         begin
            // Busy: only suspend and status read count
            if (cmd == `FCSU_CMD_SUSPEND)
               st_nxt.susp_req = 1'b1;
            st_nxt.mode = FCSU_M_STATUS;
         end
         else if (st_r.mode == FCSU_M_SETUP)
         begin
            st_nxt.mode = FCSU_M_STATUS;
            if (st_r.setup_erase && cmd != `FCSU_CMD_CONFIRM)
            begin
               // Bad erase sequence: both error flags
               st_nxt.sr[`FCSU_SR_ERS_FAIL] = 1'b1;
               st_nxt.sr[`FCSU_SR_PRG_FAIL] = 1'b1;
            end
            else if (locked)
            begin
               // Locked target: fail without touching array
               st_nxt.sr[`FCSU_SR_PROTECT] = 1'b1;
               st_nxt.sr[st_r.setup_erase ? `FCSU_SR_ERS_FAIL : `FCSU_SR_PRG_FAIL] = 1'b1;
            end
            else if (supply_low)
            begin
               st_nxt.sr[`FCSU_SR_SUPPLY_LOW] = 1'b1;
               st_nxt.sr[st_r.setup_erase ? `FCSU_SR_ERS_FAIL : `FCSU_SR_PRG_FAIL] = 1'b1;
            end
            else
            begin
               st_nxt.eng      = FCSU_E_RUN;
               st_nxt.susp_req = 1'b0; // A late suspend of the last run must not carry over
               st_nxt.op_erase = st_r.setup_erase;
               st_nxt.op_addr  = bus.addr;
               st_nxt.op_data  = cmd;
               st_nxt.cnt      = st_r.setup_erase ? `FCSU_ERASE_CYCLES : `FCSU_PROG_CYCLES;
               st_nxt.sr[`FCSU_SR_READY] = 1'b0;
            end
         end
         else
         begin
            case (cmd)
               `FCSU_CMD_READ_ARRAY:  st_nxt.mode = FCSU_M_ARRAY;
               `FCSU_CMD_READ_ID:     st_nxt.mode = FCSU_M_ID;
               `FCSU_CMD_READ_STATUS: st_nxt.mode = FCSU_M_STATUS;
               `FCSU_CMD_CLEAR_STAT:
               begin
                  // Suspend bits describe the engine, so they survive the clear
                  st_nxt.sr[`FCSU_SR_ERS_FAIL]   = 1'b0;
                  st_nxt.sr[`FCSU_SR_PRG_FAIL]   = 1'b0;
                  st_nxt.sr[`FCSU_SR_SUPPLY_LOW] = 1'b0;
                  st_nxt.sr[`FCSU_SR_PROTECT]    = 1'b0;
               end
               `FCSU_CMD_ERASE_SETUP:
               begin
                  st_nxt.mode        = FCSU_M_SETUP;
                  st_nxt.setup_erase = 1'b1;
               end
               `FCSU_CMD_PROG_SETUP, `FCSU_CMD_PROG_ALT:
               begin
                  st_nxt.mode        = FCSU_M_SETUP;
                  st_nxt.setup_erase = 1'b0;
               end
               `FCSU_CMD_CONFIRM:
               begin
                  st_nxt.mode = FCSU_M_STATUS;
                  if (st_r.eng == FCSU_E_SUSP)
                  begin
                     st_nxt.eng = FCSU_E_RUN;
                     st_nxt.sr[`FCSU_SR_READY]    = 1'b0;
                     st_nxt.sr[`FCSU_SR_ERS_SUSP] = 1'b0;
                     st_nxt.sr[`FCSU_SR_PRG_SUSP] = 1'b0;
                  end
               end
               `FCSU_CMD_SUSPEND: st_nxt.mode = FCSU_M_STATUS;
               // Reserved codes are ignored
               default: st_nxt.mode = st_r.mode;
            endcase
         end
      end

      // Read answer, one cycle later
      if (bus.rd_stb)
      begin
         st_nxt.rvalid = 1'b1;
         if (st_r.eng == FCSU_E_RUN)
            st_nxt.rdata = st_r.sr & 8'hfe;
         else
            case (st_r.mode)
               FCSU_M_ARRAY:  st_nxt.rdata = array_rdata;
               FCSU_M_ID:     st_nxt.rdata = (bus.addr[1:0] == `FCSU_ID_PART_ADDR) ?
                                             PART_CODE : MAKER_CODE;
               default:       st_nxt.rdata = st_r.sr & 8'hfe;
            endcase
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_r        <= '0;
         st_r.mode   <= FCSU_M_ARRAY;
         st_r.eng    <= FCSU_E_IDLE;
         st_r.sr     <= `FCSU_SR_RESET;
         st_r.pin_sync_n <= 3'h7; // Pin idles high: protect off
         st_r.pin_lvl_n  <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign bus.rdata       = st_r.rdata;
   assign bus.rvalid      = st_r.rvalid;
   assign array_erase_stb = st_r.ers_stb;
   assign array_prog_stb  = st_r.prg_stb;
   assign array_addr      = st_r.op_addr;
   assign array_data      = st_r.op_data;
   assign ready           = st_r.sr[`FCSU_SR_READY];
endmodule

/* File: rtl/fcsu_host.sv */
// Host end: turns user requests into single bus cycles
`include "fcsu_defs.svh"
module fcsu_host
   import fcsu_pkg::*;
#(
   parameter int AW = 20
)
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // User request port
   input  wire logic          req,
   input  wire logic [2:0]    req_op,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [7:0]    req_data,
   output logic               resp_valid,
   output logic [7:0]         resp_data,
   // Bus towards device
   fcsu_bus_if.host           bus
);
   typedef struct packed
   {
      logic          wr;
      logic          rd;
      logic [AW-1:0] addr;
      logic [7:0]    data;
      logic          rv;
      logic [7:0]    rdat;
   } fcsu_host_st_t;

   fcsu_host_st_t st_r, st_nxt;

   // One bus cycle per request; last read answer held for the user
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.wr = req && (req_op == `FCSU_HOP_WRITE);
      st_nxt.rd = req && (req_op == `FCSU_HOP_READ);
      if (req)
      begin
         st_nxt.addr = req_addr;
         st_nxt.data = req_data;
      end
      st_nxt.rv   = bus.rvalid;
      st_nxt.rdat = bus.rvalid ? bus.rdata : st_r.rdat; // Unmasked: user masks status
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign bus.wr_stb = st_r.wr;
   assign bus.rd_stb = st_r.rd;
   assign bus.addr   = st_r.addr;
   assign bus.wdata  = st_r.data;
   assign resp_valid = st_r.rv;
   assign resp_data  = st_r.rdat;
endmodule

/* File: dv/fcsu_properties.sv */
// Bus and engine property checker for the flash command unit
module fcsu_properties
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Bus
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   // Engine side
   input wire logic       ready,
   input wire logic       supply_low,
   input wire logic       array_erase_stb,
   input wire logic       array_prog_stb
);
   logic stat_r;
   logic setup_r;

   // Last write tells status mode and pending setup
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stat_r  <= 1'b0;
         setup_r <= 1'b0;
      end
      else if (wr_stb)
      begin
         stat_r  <= wdata == 8'h70;
         setup_r <= wdata == 8'h20 || wdata == 8'h40 || wdata == 8'h10;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Reads in status mode and reads while busy
   sequence s_stat_read;
      rd_stb && stat_r;
   endsequence
   sequence s_busy_read;
      rd_stb && !ready;
   endsequence

   property p_rvalid_next;
      rd_stb |=> rvalid;
   endproperty
   a_rvalid_next: assert property (p_rvalid_next)
      else $error("read answer missing");
   property p_rvalid_cause;
      rvalid |-> $past(rd_stb);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("read answer without read");
   property p_status_read;
      s_stat_read |=> rdata[7] == $past(ready) && rdata[0] == 1'b0;
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read wrong");
   property p_busy_read;
      s_busy_read |=> rdata[7] == 1'b0;
   endproperty
   a_busy_read: assert property (p_busy_read)
      else $error("busy read not status");
   property p_supply;
      array_erase_stb || array_prog_stb |-> !supply_low;
   endproperty
   a_supply: assert property (p_supply)
      else $error("array changed at low supply");
   // Single-cycle commands never start the engine
   property p_no_start;
      wr_stb && ready && !setup_r && wdata != 8'hd0 |=> ready;
   endproperty
   a_no_start: assert property (p_no_start)
      else $error("engine started without sequence");
   property p_busy_ends;
      $fell(ready) |-> ##[1:100] ready;
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("engine busy too long");
   property p_commit_pulse;
      array_erase_stb || array_prog_stb |=> !(array_erase_stb || array_prog_stb);
   endproperty
   a_commit_pulse: assert property (p_commit_pulse)
      else $error("commit strobe too long");
endmodule

/* File: dv/testbench.sv */
// Self-checking bench: host and device ends joined over the bus
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MAKER_CODE = 8'h5a; // Arbitrary value
   localparam logic [7:0] PART_CODE  = 8'h3c; // Arbitrary value
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   logic [2:0]  req_op = 3'h0;
   logic [19:0] req_addr = 20'h0;
   logic [7:0]  req_data = 8'h0;
   logic        supply_low = 1'b0;
   logic        pin_n = 1'b1;
   logic [15:0] block_lock = 16'h0;
   logic [7:0]  arr_rd = 8'h6e;
   logic        resp_valid, ready, ers, prg;
   logic [7:0]  resp_data, arr_d, prg_d;
   logic [19:0] arr_a, ers_a;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          n_ers = 0;
   int          n_prg = 0;

   always #10 clock = ~clock;

   fcsu_bus_if #(.AW(20)) link ();
   fcsu_host #(.AW(20)) i_fcsu_host (.clock, .rst, .req, .req_op, .req_addr, .req_data,
      .resp_valid, .resp_data, .bus(link));
   fcsu_device i_fcsu_device (.clock, .rst, .bus(link), .supply_low, .block_lock,
      .top_block_protect_pin_n(pin_n), .array_erase_stb(ers), .array_prog_stb(prg),
      .array_addr(arr_a), .array_data(arr_d), .array_rdata(arr_rd), .ready);
   fcsu_properties i_fcsu_properties (.clock, .rst, .wr_stb(link.wr_stb),
      .rd_stb(link.rd_stb), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
      .ready, .supply_low, .array_erase_stb(ers), .array_prog_stb(prg));

   // Count array commits so refused operations show
   always @(posedge clock)
   begin
      if (ers)
      begin
         n_ers++;
         ers_a = arr_a;
      end
      if (prg)
      begin
         n_prg++;
         prg_d = arr_d;
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clock);
      req      <= 1'b1;
      req_op   <= 3'h1;
      req_addr <= a;
      req_data <= d;
      @(posedge clock);
      req <= 1'b0;
   endtask

   // Masked read; bits under a busy flag are not meaningful
   task automatic rd(input logic [19:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      int n;
      @(posedge clock);
      req      <= 1'b1;
      req_op   <= 3'h0;
      req_addr <= a;
      @(posedge clock);
      req <= 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      // A missing answer must not pass on stale held data
      chk("read answer", 8'h1, {7'h0, resp_valid});
      chk("read data", e, resp_data & m);
   endtask

   task automatic idle();
      int n;
      n = 0;
      repeat (3) @(posedge clock);
      while (ready !== 1'b1 && n < 200)
      begin
         @(posedge clock);
         n++;
      end
      chk("ready", 8'h1, {7'h0, ready});
   endtask

   // Clear flags, two-write sequence, then status
   task automatic op(input logic [19:0] a, input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] e);
      wr(a, 8'h50);
      wr(a, c);
      wr(a, d);
      idle();
      wr(a, 8'h70);
      rd(a ^ 20'h5, e);
   endtask

   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(20'h0, 8'h6e);
      wr(20'h3_1234, 8'h70);
      rd(20'h0_0007, 8'h80);
      rd(20'h0_0008, 8'h80, 8'hfe);
      wr(20'h0_0055, 8'hff);
      rd(20'h0, 8'h6e);
      wr(20'h9_0000, 8'h90);
      rd(20'h0, MAKER_CODE);
      rd(20'h1, PART_CODE);
      $display("test modes done");
      op(20'h2_0040, 8'h40, 8'h99, 8'h80);
      chk("program data", 8'h99, prg_d);
      op(20'h2_0041, 8'h10, 8'h33, 8'h80);
      op(20'h5_0123, 8'h20, 8'hd0, 8'h80);
      chk("erase block", 8'h5, {4'h0, ers_a[19:16]});
      block_lock[1] <= 1'b1;
      op(20'h1_0000, 8'h40, 8'h00, 8'h92);
      op(20'h1_0000, 8'h20, 8'hd0, 8'ha2);
      block_lock[1] <= 1'b0;
      pin_n <= 1'b0;
      op(20'hf_0000, 8'h20, 8'hd0, 8'ha2);
      pin_n <= 1'b1;
      supply_low <= 1'b1;
      op(20'h3_0000, 8'h20, 8'hd0, 8'ha8);
      op(20'h3_0000, 8'h40, 8'h12, 8'h98);
      supply_low <= 1'b0;
      op(20'h3_0000, 8'h20, 8'hff, 8'hb0);
      wr(20'h4_0000, 8'h40);
      wr(20'h4_0000, 8'h77);
      idle();
      rd(20'h0, 8'hb0);
      $display("test operations done");
      op(20'h6_0000, 8'h70, 8'h70, 8'h80);
      wr(20'h6_0000, 8'h20);
      wr(20'h6_0000, 8'hd0);
      wr(20'h0, 8'hff);
      rd(20'h0, 8'h00, 8'h80);
      wr(20'h0, 8'hb0);
      repeat (4) @(posedge clock);
      rd(20'h0, 8'hc0);
      wr(20'h0, 8'hd0);
      idle();
      rd(20'h0, 8'h80);
      wr(20'h6_0010, 8'h40);
      wr(20'h6_0010, 8'h5a);
      wr(20'h0, 8'hb0);
      repeat (2) @(posedge clock);
      rd(20'h0, 8'h84);
      wr(20'h0, 8'hd0);
      idle();
      rd(20'h0, 8'h80);
      chk("program count", 8'h4, 8'(n_prg));
      chk("erase count", 8'h2, 8'(n_ers));
      $display("test suspend done");
      // Reset in the middle of an erase: no commit, back in read array
      wr(20'h7_0000, 8'h20);
      wr(20'h7_0000, 8'hd0);
      repeat (4) @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(20'h7_0000, 8'h6e);
      idle();
      chk("erase count after reset", 8'h2, 8'(n_ers));
      $display("test reset done");
      report_and_stop();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      report_and_stop();
   end
endmodule
